// ===== design/tbpwm_pkg.sv
// Package of register offsets, field layouts, reset values and timing constants for the timer-based modulator.
package tbpwm_pkg;
  // Register indices on the plain register port.
  localparam logic [2:0] OFF_PERIOD_LIMIT = 3'h0;
  localparam logic [2:0] OFF_DUTY_LOW = 3'h1;
  localparam logic [2:0] OFF_DUTY_ACTIVE = 3'h2;
  localparam logic [2:0] OFF_CONTROL = 3'h3;
  localparam logic [2:0] OFF_TIMER_CTRL = 3'h4;
  localparam logic [2:0] OFF_TIMER_COUNT = 3'h5;
  localparam logic [2:0] OFF_STATUS = 3'h6;
  // Control register fields.
  localparam int CTRL_DUTY_LSB_HI = 5;
  localparam int CTRL_DUTY_LSB_LO = 4;
  localparam int CTRL_MODE_HI = 3;
  localparam int CTRL_MODE_LO = 0;
  localparam logic [3:0] MODE_MODULATE = 4'hC;
  localparam logic [3:0] MODE_MODULATE_MASK = 4'hC;
  // Timer control fields: prescale select in bits 1:0, run enable bit 2, postscale in bits 6:3.
  localparam int TCTRL_PRE_HI = 1;
  localparam int TCTRL_PRE_LO = 0;
  localparam int TCTRL_RUN = 2;
  localparam int TCTRL_POST_HI = 6;
  localparam int TCTRL_POST_LO = 3;
  // Reset values.
  localparam logic [7:0] PERIOD_LIMIT_RST = 8'hFF;
  localparam logic [7:0] DUTY_LOW_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
  // One instruction cycle is four oscillator clocks.
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYCLE - 1);
  // Prescale selects: 1, 4 and 16 instruction cycles per timer increment.
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
  localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;
endpackage : tbpwm_pkg

// ===== design/tbpwm_prescaler.sv
// Instruction-phase counter and timer prescaler producing the period timer's increment strobe.
`timescale 1ns/1ns
`default_nettype none
module tbpwm_prescaler (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [1:0] pre_sel_i,
  output logic tick_o,
  output logic [1:0] fine_o
);
  typedef struct packed {
    logic [1:0] phase;
    logic [3:0] pre;
  } tbpwm_pre_state_t;

  tbpwm_pre_state_t st_r;
  tbpwm_pre_state_t st_nxt;
  logic [3:0] pre_last;
  logic cyc_end;

  // Last prescaler count for the selected ratio.
  always_comb begin
    case (pre_sel_i)
      tbpwm_pkg::PRE_DIV1: pre_last = 4'h0;
      tbpwm_pkg::PRE_DIV4: pre_last = tbpwm_pkg::PRE_LAST_DIV4;
      default: pre_last = tbpwm_pkg::PRE_LAST_DIV16;
    endcase
  end

  assign cyc_end = (st_r.phase == tbpwm_pkg::PHASE_LAST);
  assign tick_o = run_i && cyc_end && (st_r.pre == pre_last);

  // Fine bits of the coming cycle: phase at 1:1, prescaler bits 1:0 at 1:4 and bits 3:2 at 1:16.
  // They look one step ahead because the output latch is registered and would otherwise fall a clock late.
  always_comb begin
    if (pre_sel_i == tbpwm_pkg::PRE_DIV1) begin
      fine_o = st_nxt.phase;
    end else if (pre_sel_i == tbpwm_pkg::PRE_DIV4) begin
      fine_o = st_nxt.pre[1:0];
    end else begin
      fine_o = st_nxt.pre[3:2];
    end
  end

  // Phase always rolls; the prescaler only counts while the timer runs.
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = st_r.phase + 2'h1;
    if (!run_i) begin
      st_nxt.pre = 4'h0;
    end else if (cyc_end) begin
      st_nxt.pre = (st_r.pre >= pre_last) ? 4'h0 : st_r.pre + 4'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end
endmodule : tbpwm_prescaler
`default_nettype wire

// ===== design/tbpwm_top.sv
// Timer-based single-channel pulse-width modulator with its period timer and register port.
//
// Function
// - The period is (period limit + 1) times four oscillator clocks times the prescale ratio, set by software.
// - When the timer equals the period limit it clears on the next increment, starting a new period.
// - At each rollover the output goes high unless the duty value is zero.
// - At each rollover in modulation mode the written duty value is copied into the active compare buffer.
// - The postscaler only makes a separate update event and never alters the modulator's period.
// - The duty value is ten bits: eight high bits from the duty low byte, two low bits from control bits 5:4.
// - The high time is the ten-bit duty value times one oscillator clock times the prescale ratio.
// - Duty writes are taken at any time but act only after the next rollover transfers them.
// - In modulation mode the active duty buffer reads back but ignores writes.
// - The active duty lives in the buffer byte plus a two-bit latch, both loaded together at rollover.
// - The output goes low when the buffered duty equals the timer extended by two fine bits.
// - A duty value beyond the period gives no clearing match, so the output stays high all period.
// - Writing zero to the whole control register forces the modulator output latch low.
`timescale 1ns/1ns
`default_nettype none
module tbpwm_top (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] port_c_direction_bits_i,
  input wire logic port_c_data_i,
  output logic modulated_output_pin_o,
  output logic modulated_output_pin_oe_o,
  output logic postscale_event_o
);
  typedef struct packed {
    logic [7:0] period_limit_register;
    logic [7:0] duty_low_byte;
    logic [7:0] duty_active_buffer;
    logic [1:0] duty_active_lsb;
    logic [7:0] capture_modulator_control;
    logic [7:0] timer_ctrl;
    logic [7:0] period_timer_count;
    logic [3:0] post_count;
    logic out_latch;
    logic post_event;
    logic [7:0] rdata;
  } tbpwm_state_t;

  tbpwm_state_t st_r;
  tbpwm_state_t st_nxt;
  logic tick;
  logic [1:0] fine;
  logic pwm_mode;
  logic match;
  logic rollover;
  logic [9:0] duty_written;
  logic [9:0] duty_active;
  logic [9:0] timer_ext;
  logic [7:0] count_next;

  // Decodes whether a control value selects modulation mode.
  function automatic logic tbpwm_is_pwm(input logic [7:0] ctrl);
    tbpwm_is_pwm = (ctrl[tbpwm_pkg::CTRL_MODE_HI:tbpwm_pkg::CTRL_MODE_LO] & tbpwm_pkg::MODE_MODULATE_MASK)
                   == tbpwm_pkg::MODE_MODULATE;
  endfunction : tbpwm_is_pwm

  tbpwm_prescaler u_prescaler (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .run_i(st_r.timer_ctrl[tbpwm_pkg::TCTRL_RUN]),
    .pre_sel_i(st_r.timer_ctrl[tbpwm_pkg::TCTRL_PRE_HI:tbpwm_pkg::TCTRL_PRE_LO]),
    .tick_o(tick),
    .fine_o(fine)
  );

  // Period match and the ten-bit duty words.
  assign pwm_mode = tbpwm_is_pwm(st_r.capture_modulator_control);
  assign match = (st_r.period_timer_count == st_r.period_limit_register);
  assign rollover = tick && match;
  assign duty_written = {st_r.duty_low_byte,
                         st_r.capture_modulator_control[tbpwm_pkg::CTRL_DUTY_LSB_HI:tbpwm_pkg::CTRL_DUTY_LSB_LO]};
  assign duty_active = {st_r.duty_active_buffer, st_r.duty_active_lsb};
  // Timer value of the coming cycle; comparing one step ahead lets the registered latch fall on the duty boundary.
  assign count_next = tick ? (match ? 8'h00 : st_r.period_timer_count + 8'h01) : st_r.period_timer_count;
  assign timer_ext = {count_next, fine};

  // Next-state logic: timer, double buffer, output latch, postscaler and register port.
  always_comb begin
    st_nxt = st_r;
    st_nxt.post_event = 1'b0;
    // Timer advance and clear at the period match.
    st_nxt.period_timer_count = count_next;
    // Output latch: compare clears, rollover sets; the rollover wins over a same-cycle clear.
    if (pwm_mode && (duty_active == timer_ext)) begin
      st_nxt.out_latch = 1'b0;
    end
    if (pwm_mode && rollover) begin
      st_nxt.duty_active_buffer = st_r.duty_low_byte;
      st_nxt.duty_active_lsb = duty_written[1:0];
      st_nxt.out_latch = (duty_written != 10'h000);
    end
    if (!pwm_mode) begin
      st_nxt.out_latch = 1'b0;
    end
    // Postscaler counts period matches for an update event only.
    if (rollover) begin
      if (st_r.post_count >= st_r.timer_ctrl[tbpwm_pkg::TCTRL_POST_HI:tbpwm_pkg::TCTRL_POST_LO]) begin
        st_nxt.post_count = 4'h0;
        st_nxt.post_event = 1'b1;
      end else begin
        st_nxt.post_count = st_r.post_count + 4'h1;
      end
    end
    // Register writes; duty writes land in the software copy and wait for rollover.
    if (wr_i) begin
      case (addr_i)
        tbpwm_pkg::OFF_PERIOD_LIMIT: st_nxt.period_limit_register = wdata_i;
        tbpwm_pkg::OFF_DUTY_LOW: st_nxt.duty_low_byte = wdata_i;
        tbpwm_pkg::OFF_DUTY_ACTIVE: begin
          if (!pwm_mode) begin
            st_nxt.duty_active_buffer = wdata_i;
          end
        end
        tbpwm_pkg::OFF_CONTROL: begin
          st_nxt.capture_modulator_control = wdata_i;
          if (wdata_i == 8'h00) begin
            st_nxt.out_latch = 1'b0;
          end
        end
        tbpwm_pkg::OFF_TIMER_CTRL: st_nxt.timer_ctrl = wdata_i;
        tbpwm_pkg::OFF_TIMER_COUNT: st_nxt.period_timer_count = wdata_i;
        default: st_nxt.rdata = st_r.rdata;
      endcase
    end
    // Read data stand only in the cycle after the read strobe.
    st_nxt.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        tbpwm_pkg::OFF_PERIOD_LIMIT: st_nxt.rdata = st_r.period_limit_register;
        tbpwm_pkg::OFF_DUTY_LOW: st_nxt.rdata = st_r.duty_low_byte;
        tbpwm_pkg::OFF_DUTY_ACTIVE: st_nxt.rdata = st_r.duty_active_buffer;
        tbpwm_pkg::OFF_CONTROL: st_nxt.rdata = st_r.capture_modulator_control;
        tbpwm_pkg::OFF_TIMER_CTRL: st_nxt.rdata = st_r.timer_ctrl;
        tbpwm_pkg::OFF_TIMER_COUNT: st_nxt.rdata = st_r.period_timer_count;
        tbpwm_pkg::OFF_STATUS: st_nxt.rdata = {6'h00, st_r.duty_active_lsb[1], st_r.out_latch};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r.period_limit_register <= tbpwm_pkg::PERIOD_LIMIT_RST;
      st_r.duty_low_byte <= tbpwm_pkg::DUTY_LOW_RST;
      st_r.duty_active_buffer <= 8'h00;
      st_r.duty_active_lsb <= 2'h0;
      st_r.capture_modulator_control <= tbpwm_pkg::CONTROL_RST;
      st_r.timer_ctrl <= tbpwm_pkg::TIMER_CTRL_RST;
      st_r.period_timer_count <= 8'h00;
      st_r.post_count <= 4'h0;
      st_r.out_latch <= 1'b0;
      st_r.post_event <= 1'b0;
      st_r.rdata <= 8'h00;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // Pin mux: the direction bit decides whether the pin drives; modulation replaces the port data.
  assign modulated_output_pin_oe_o = !port_c_direction_bits_i[2];
  assign modulated_output_pin_o = pwm_mode ? st_r.out_latch : port_c_data_i;
  assign postscale_event_o = st_r.post_event;
  assign rdata_o = st_r.rdata;
endmodule : tbpwm_top
`default_nettype wire

// ===== dv/tbpwm_chk.sv
// Concurrent checks on the modulator's register port and pin.
`timescale 1ns/1ns
`default_nettype none
module tbpwm_chk (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] port_c_direction_bits_i,
  input wire logic port_c_data_i,
  input wire logic modulated_output_pin_o,
  input wire logic modulated_output_pin_oe_o,
  input wire logic postscale_event_o
);
  // Every check lives in the one clock domain.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_pin_drive_dir: assert property (modulated_output_pin_oe_o == !port_c_direction_bits_i[2])
    else $error("pin enable disagrees with direction bit");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_read: assert property (rd_i && ce_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_clear_low: assert property (wr_i && ce_i && addr_i == tbpwm_pkg::OFF_CONTROL && wdata_i == 8'h00
    |=> modulated_output_pin_o == port_c_data_i)
    else $error("clearing control did not release pin to port data");
  a_post_one_cycle: assert property (postscale_event_o |=> !postscale_event_o)
    else $error("postscale event longer than one cycle");
  a_period_readback: assert property (wr_i && ce_i && addr_i == tbpwm_pkg::OFF_PERIOD_LIMIT ##1 !wr_i
    ##1 rd_i && ce_i && addr_i == tbpwm_pkg::OFF_PERIOD_LIMIT |=> rdata_o == $past(wdata_i, 3))
    else $error("period limit readback wrong");
  a_duty_readback: assert property (wr_i && ce_i && addr_i == tbpwm_pkg::OFF_DUTY_LOW ##1 !wr_i
    ##1 rd_i && ce_i && addr_i == tbpwm_pkg::OFF_DUTY_LOW |=> rdata_o == $past(wdata_i, 3))
    else $error("duty low byte readback wrong");
  // With port data low the pin equals the output latch in either mode.
  a_status_latch: assert property (rd_i && addr_i == tbpwm_pkg::OFF_STATUS && !port_c_data_i
    |=> rdata_o[0] == $past(modulated_output_pin_o))
    else $error("status latch bit disagrees with pin");
endmodule : tbpwm_chk
bind tbpwm_top tbpwm_chk chk_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .port_c_direction_bits_i(port_c_direction_bits_i), .port_c_data_i(port_c_data_i),
  .modulated_output_pin_o(modulated_output_pin_o), .modulated_output_pin_oe_o(modulated_output_pin_oe_o),
  .postscale_event_o(postscale_event_o));
`default_nettype wire

// ===== dv/tbpwm_load.sv
// Load on the modulated pin that measures period and high time.
`timescale 1ns/1ns
`default_nettype none
module tbpwm_load (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  input wire logic oe_i,
  output logic [15:0] period_o,
  output logic [15:0] high_o,
  output logic [15:0] hi_total_o
);
  logic lvl;
  logic prev_r;
  logic [15:0] cnt_r;
  logic [15:0] hcnt_r;
  // An undriven pin is held low by the load's pull-down.
  assign lvl = oe_i ? pin_i : 1'b0;
  // A rising edge closes one period; the high count covers the same span.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {prev_r, cnt_r, hcnt_r, period_o, high_o, hi_total_o} <= '0;
    end else begin
      prev_r <= lvl;
      hi_total_o <= hi_total_o + 16'(lvl);
      if (lvl && !prev_r) begin
        period_o <= cnt_r;
        high_o <= hcnt_r;
        cnt_r <= 16'h0001;
        hcnt_r <= 16'h0001;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
        hcnt_r <= hcnt_r + 16'(lvl);
      end
    end
  end
endmodule : tbpwm_load
`default_nettype wire

// ===== dv/test_timer_based_pwm_output.sv
// Self-checking bench for the timer-based modulator.
`timescale 1ns/1ns
`default_nettype none
module test_timer_based_pwm_output;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] dir = 8'hFF;
  logic pdata = 1'b0;
  logic ce = 1'b1;
  logic post_ev;
  logic [15:0] post_n = 16'h0000;
  logic [7:0] rdata_o;
  logic pin;
  logic oe;
  logic [15:0] period;
  logic [15:0] high;
  logic [15:0] hi_total;
  logic [15:0] h0;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #50 clock_i = ~clock_i;
  tbpwm_top dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_c_direction_bits_i(dir), .port_c_data_i(pdata),
    .modulated_output_pin_o(pin), .modulated_output_pin_oe_o(oe), .postscale_event_o(post_ev));
  // Counts postscaler update pulses for the event-rate checks.
  always @(posedge clock_i) begin
    if (post_ev) begin
      post_n <= post_n + 16'h0001;
    end
  end
  tbpwm_load load_u (.clock_i(clock_i), .rst_b_i(rst_b_i), .pin_i(pin), .oe_i(oe), .period_o(period),
    .high_o(high), .hi_total_o(hi_total));
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Each access starts one edge later, so strobes never toggle twice in a step.
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk({8'h00, rdata_o}, {8'h00, exp});
  endtask : rd_chk
  // High cycles and postscale pulses over a 32-cycle window; one pulse per two 16-cycle periods.
  task automatic high_cycles(input logic [15:0] exp);
    logic [15:0] p0;
    repeat (40) @(posedge clock_i);
    h0 = hi_total;
    p0 = post_n;
    repeat (32) @(posedge clock_i);
    chk(hi_total - h0, exp);
    chk(post_n - p0, 16'd1);
  endtask : high_cycles
  // A hang is cut short well beyond the roughly 1,300 cycles the run needs.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd_chk(tbpwm_pkg::OFF_PERIOD_LIMIT, tbpwm_pkg::PERIOD_LIMIT_RST);
    rd_chk(tbpwm_pkg::OFF_DUTY_LOW, tbpwm_pkg::DUTY_LOW_RST);
    rd_chk(3'h7, 8'h00);
    // A write while the clock enable is low must not land.
    @(posedge clock_i);
    dir <= 8'hFB;
    ce <= 1'b0;
    wr_reg(tbpwm_pkg::OFF_PERIOD_LIMIT, 8'h55);
    ce <= 1'b1;
    rd_chk(tbpwm_pkg::OFF_PERIOD_LIMIT, tbpwm_pkg::PERIOD_LIMIT_RST);
    wr_reg(tbpwm_pkg::OFF_PERIOD_LIMIT, 8'h03);
    rd_chk(tbpwm_pkg::OFF_PERIOD_LIMIT, 8'h03);
    wr_reg(tbpwm_pkg::OFF_DUTY_LOW, 8'h02);
    rd_chk(tbpwm_pkg::OFF_DUTY_LOW, 8'h02);
    wr_reg(tbpwm_pkg::OFF_CONTROL, 8'h1C);
    wr_reg(tbpwm_pkg::OFF_TIMER_CTRL, 8'h0C);
    repeat (80) @(posedge clock_i);
    @(negedge clock_i);
    chk(period, 16'd16);
    chk(high, 16'd9);
    // Prescale 1:4 and 1:16 stretch both the period and the high time by the ratio.
    wr_reg(tbpwm_pkg::OFF_TIMER_CTRL, 8'h0D);
    repeat (200) @(posedge clock_i);
    @(negedge clock_i);
    chk(period, 16'd64);
    chk(high, 16'd36);
    wr_reg(tbpwm_pkg::OFF_TIMER_CTRL, 8'h0E);
    repeat (800) @(posedge clock_i);
    @(negedge clock_i);
    chk(period, 16'd256);
    chk(high, 16'd144);
    wr_reg(tbpwm_pkg::OFF_TIMER_CTRL, 8'h0C);
    wr_reg(tbpwm_pkg::OFF_DUTY_ACTIVE, 8'hAA);
    rd_chk(tbpwm_pkg::OFF_DUTY_ACTIVE, 8'h02);
    wr_reg(tbpwm_pkg::OFF_DUTY_LOW, 8'h10);
    high_cycles(16'd32);
    rd_chk(tbpwm_pkg::OFF_STATUS, 8'h01);
    wr_reg(tbpwm_pkg::OFF_DUTY_LOW, 8'h00);
    wr_reg(tbpwm_pkg::OFF_CONTROL, 8'h0C);
    high_cycles(16'd0);
    wr_reg(tbpwm_pkg::OFF_CONTROL, 8'h00);
    pdata <= 1'b1;
    @(posedge clock_i);
    @(negedge clock_i);
    chk({15'h0000, pin}, 16'h0001);
    rd_chk(tbpwm_pkg::OFF_STATUS, 8'h00);
    end_of_test();
  end
endmodule : test_timer_based_pwm_output
`default_nettype wire
